// ===== logic/dkus_pkg.sv
// constants and types shared by the debug key unlock sequencer
`default_nettype none
package dkus_pkg;
    // control-space register byte addresses (haddr[31:8] must be zero)
    localparam logic [7:0] ADDR_KEY_INSTR  = 8'h00;
    localparam logic [7:0] ADDR_KEY_DATA   = 8'h04;
    localparam logic [7:0] ADDR_ID_DATA    = 8'h08;
    localparam logic [7:0] ADDR_KEY_STATE  = 8'h0C;
    localparam logic [7:0] ADDR_RST_REQ    = 8'h10;
    localparam logic [7:0] ADDR_SYS_CTRL   = 8'h14;
    localparam logic [7:0] ADDR_SYS_STATE  = 8'h18;
    // row staging window: 0x80..0xFC, one byte per word
    localparam int         ROW_WIN_BIT     = 7;
    localparam int         ROW_BYTES       = 32;
    localparam int         ROW_IDX_W       = 5;
    // key instruction fields
    localparam int         KI_INFO         = 0;
    localparam int         KI_SIZE16       = 1;
    localparam logic [4:0] ID_LEN_FULL     = 5'h10;
    localparam logic [4:0] ID_LEN_FAMILY   = 5'h08;
    localparam logic [2:0] KEY_LAST_BYTE   = 3'h7;
    // key state bits
    localparam int         KS_ERASE        = 3;
    localparam int         KS_PROG         = 4;
    localparam int         KS_ROW          = 5;
    // system control bits
    localparam int         SC_CLKREQ       = 0;
    localparam int         SC_COMMIT       = 1;
    localparam logic       CLKREQ_RST      = 1'b1;
    // system state bits
    localparam int         SS_LOCK         = 0;
    localparam int         SS_ROWPROG      = 2;
    localparam int         SS_PROG         = 3;
    localparam int         SS_SLEEP        = 4;
    localparam int         SS_RSTSYS       = 5;
    // key signatures
    localparam logic [63:0] KEY_ERASE_SIG  = 64'h4E564D4572617365;
    localparam logic [63:0] KEY_PROG_SIG   = 64'h4E564D50726F6720;
    localparam logic [63:0] KEY_ROW_SIG    = 64'h4E564D5573267465;
    localparam logic [7:0]  RST_RELEASE    = 8'h00;

    typedef enum logic [2:0] {
        DKUS_IDLE   = 3'b001,
        DKUS_ERASE  = 3'b010,
        DKUS_COMMIT = 3'b100
    } dkus_state_t;
endpackage
`default_nettype wire

// ===== logic/dkus_row_if.sv
// carrier between the sequencer and its row staging buffer
`timescale 1ns/1ps
`default_nettype none
interface dkus_row_if;
    import dkus_pkg::*;
    logic                 wr;
    logic [ROW_IDX_W-1:0] idx;
    logic [7:0]           data;
    logic                 commit;
    logic                 done;
    modport ctrl  (output wr, output idx, output data, output commit, input done);
    modport stage (input wr, input idx, input data, input commit, output done);
endinterface
`default_nettype wire

// ===== logic/dkus_row_stage.sv
// 32-byte staging ram and user configuration row image
`timescale 1ns/1ps
`default_nettype none
module dkus_row_stage
    import dkus_pkg::*;
(
    input  wire logic                  hclk,            // system clock
    input  wire logic                  hresetn,         // async reset, low
    dkus_row_if.stage                  rif,             // staging port
    output logic [ROW_BYTES*8-1:0]     user_config_row  // committed row image
);
    logic [7:0]               mem      [ROW_BYTES];
    logic [7:0]               next_mem [ROW_BYTES];
    logic [ROW_BYTES*8-1:0]   next_row;
    logic                     next_done;

    always_comb
    begin
        next_mem  = mem;
        next_row  = user_config_row;
        next_done = 1'b0;
        if (rif.wr)
        begin
            next_mem[rif.idx] = rif.data;
        end
        if (rif.commit)
        begin
            // byte n of the staging ram lands on byte n of the row
            for (int i = 0; i < ROW_BYTES; i++)
            begin
                next_row[i*8 +: 8] = mem[i];
            end
            next_done = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < ROW_BYTES; i++)
            begin
                mem[i] <= 8'h00;
            end
            user_config_row <= '0;
            rif.done        <= 1'b0;
        end
        else
        begin
            mem             <= next_mem;
            user_config_row <= next_row;
            rif.done        <= next_done;
        end
    end
endmodule
`default_nettype wire

// ===== logic/dkus_top.sv
// debug key unlock sequencer with ahb-lite control space
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - info select returns identification block always
// - ascii block, 16 bytes or 8 family
// - fixed byte layout of identification block
// - 64-bit keys, lsb first, exact match
// - any key order; erase keeps program key
// - erase key unconditional, cleared by disable/reset
// - program key needs unlock, ends after programming
// - row key needs lock, cleared by write
// - accepted keys shown in key state bits
// - reset signature holds system reset; zero releases
// - locked part blocks system bus access
// - erase forces brownout detector on, fuse level
// - row mode accepts only 32 staged bytes
// - commit bit copies row, clears flag
// - row mode refuses sram read-back
// - event on each sync character rising edge
// - keys 64 bits, block at most 128
// - no reply to keys; block after guard
// - control space reachable only from debug bus
module dkus_top
    import dkus_pkg::*;
#(
    parameter logic [55:0] FAMILY_IDENTIFIER   = 56'h20202020202020, // arbitrary
    parameter logic [23:0] MEMCTL_VERSION      = 24'h303030,         // arbitrary
    parameter logic [23:0] DEBUG_VERSION       = 24'h303030,         // arbitrary
    parameter logic [7:0]  DEBUG_OSC_FREQUENCY = 8'h30,              // arbitrary
    parameter logic [7:0]  RESET_SIGNATURE     = 8'hA5
)(
    input  wire logic                      hclk,             // clock
    input  wire logic                      hresetn,          // interface reset
    input  wire logic                      hsel,             // slave select
    input  wire logic [31:0]               haddr,            // address
    input  wire logic [1:0]                htrans,           // transfer type
    input  wire logic                      hwrite,           // write
    input  wire logic [2:0]                hsize,            // size
    input  wire logic [31:0]               hwdata,           // write data
    input  wire logic                      hready,           // bus ready
    output logic [31:0]                    hrdata,           // read data
    output logic                           hreadyout,        // slave ready
    output logic                           hresp,            // response
    input  wire logic                      link_disable,     // interface disabled
    input  wire logic                      lock_fuse,        // lock bits at start
    input  wire logic                      erase_done,       // full erase finished
    input  wire logic                      system_sleeping,  // system domain asleep
    input  wire logic [2:0]                bod_fuse_level,   // brownout fuse level
    input  wire logic                      sync_line,        // received line level
    input  wire logic                      sync_window,      // sync character active
    output logic                           sys_reset,        // system reset hold
    output logic                           erase_start,      // erase start pulse
    output logic                           sysbus_allow,     // system bus open
    output logic                           sram_read_allow,  // sram read-back open
    output logic                           brownout_force,   // brownout forced on
    output logic [2:0]                     brownout_level,   // forced threshold
    output logic                           clock_request,    // keep system clock
    output logic                           sync_event,       // sync edge event
    output logic [ROW_BYTES*8-1:0]         user_config_row   // committed row
);
    //////////////////////////////////////////////////////////////////////////
    // byte 0 of the block is the lowest byte
    localparam logic [127:0] ID_BLOCK = {DEBUG_OSC_FREQUENCY, 8'h00, DEBUG_VERSION,
                                         MEMCTL_VERSION, 8'h00, FAMILY_IDENTIFIER};

    function automatic logic [7:0] id_byte(input logic [3:0] ptr);
        id_byte = ID_BLOCK[{ptr, 3'b000} +: 8];
    endfunction

    // returns {row, prog, erase}
    function automatic logic [2:0] key_kind(input logic [63:0] k);
        key_kind = {k == KEY_ROW_SIG, k == KEY_PROG_SIG, k == KEY_ERASE_SIG};
    endfunction

    dkus_row_if rif ();

    dkus_row_stage u_stage (
        .hclk            (hclk),
        .hresetn         (hresetn),
        .rif             (rif.stage),
        .user_config_row (user_config_row)
    );

    //////////////////////////////////////////////////////////////////////////
    dkus_state_t   state,       next_state;
    logic          dp_wr,       next_dp_wr;
    logic [7:0]    dp_addr,     next_dp_addr;
    logic [31:0]   next_hrdata;
    logic          key_armed,   next_key_armed;
    logic [2:0]    key_cnt,     next_key_cnt;
    logic [63:0]   key_sh,      next_key_sh;
    logic [3:0]    id_ptr,      next_id_ptr;
    logic [4:0]    id_left,     next_id_left;
    logic          erase_key,   next_erase_key;
    logic          prog_key,    next_prog_key;
    logic          row_key,     next_row_key;
    logic          prog_flag,   next_prog_flag;
    logic          row_flag,    next_row_flag;
    logic          commit_bit,  next_commit_bit;
    logic          clkreq,      next_clkreq;
    logic          lock,        next_lock;
    logic          lock_init,   next_lock_init;
    logic [7:0]    rst_req,     next_rst_req;
    logic          next_sys_reset;
    logic          next_erase_start;
    logic          next_row_wr;
    logic [ROW_IDX_W-1:0] next_row_idx;
    logic [7:0]    next_row_data;
    logic          next_row_commit;
    logic          sync_prev;
    logic          next_sync_event;
    logic [7:0]    ks_byte;
    logic [7:0]    ss_byte;
    logic [63:0]   shifted;
    logic [2:0]    key_hit;
    logic          addr_phase;

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel && htrans[1] && hready && (haddr[31:8] == 24'h000000);

    always_comb
    begin
        ks_byte             = 8'h00;
        ks_byte[KS_ERASE]   = erase_key;
        ks_byte[KS_PROG]    = prog_key;
        ks_byte[KS_ROW]     = row_key;
        ss_byte             = 8'h00;
        ss_byte[SS_LOCK]    = lock;
        ss_byte[SS_ROWPROG] = row_flag;
        ss_byte[SS_PROG]    = prog_flag;
        ss_byte[SS_SLEEP]   = system_sleeping;
        ss_byte[SS_RSTSYS]  = sys_reset;
        shifted             = {hwdata[7:0], key_sh[63:8]};
        key_hit             = key_kind(shifted);
        next_state       = state;
        next_dp_wr       = addr_phase && hwrite;
        next_dp_addr     = haddr[7:0];
        next_hrdata      = 32'h00000000;
        next_key_armed   = key_armed;
        next_key_cnt     = key_cnt;
        next_key_sh      = key_sh;
        next_id_ptr      = id_ptr;
        next_id_left     = id_left;
        next_erase_key   = erase_key;
        next_prog_key    = prog_key;
        next_row_key     = row_key;
        next_prog_flag   = prog_flag;
        next_row_flag    = row_flag;
        next_commit_bit  = commit_bit;
        next_clkreq      = clkreq;
        next_lock        = lock;
        next_lock_init   = 1'b1;
        next_rst_req     = rst_req;
        next_erase_start = 1'b0;
        next_row_wr      = 1'b0;
        next_row_idx     = dp_addr[ROW_IDX_W+1:2];
        next_row_data    = hwdata[7:0];
        next_row_commit  = 1'b0;

        // strap the lock bits once, the cycle after reset release
        if (!lock_init)
        begin
            next_lock = lock_fuse;
        end

        // read data is prepared at the address phase; unmapped reads give zero
        if (addr_phase && !hwrite)
        begin
            case (haddr[7:0])
                ADDR_ID_DATA:
                begin
                    if (id_left != 5'h00)
                    begin
                        next_hrdata  = {24'h000000, id_byte(id_ptr)};
                        next_id_ptr  = id_ptr + 4'h1;
                        next_id_left = id_left - 5'h01;
                    end
                end
                ADDR_KEY_STATE: next_hrdata = {24'h000000, ks_byte};
                ADDR_RST_REQ:   next_hrdata = {24'h000000, rst_req};
                ADDR_SYS_CTRL:  next_hrdata = {30'h00000000, commit_bit, clkreq};
                ADDR_SYS_STATE: next_hrdata = {24'h000000, ss_byte};
                // staged row bytes never read back
                default:        next_hrdata = 32'h00000000;
            endcase
        end

        if (dp_wr)
        begin
            case (dp_addr)
                ADDR_KEY_INSTR:
                begin
                    if (hwdata[KI_INFO])
                    begin
                        // served regardless of lock or key state
                        next_id_ptr    = 4'h0;
                        next_id_left   = hwdata[KI_SIZE16] ? ID_LEN_FULL
                                                           : ID_LEN_FAMILY;
                        next_key_armed = 1'b0;
                    end
                    else
                    begin
                        next_key_armed = 1'b1;
                        next_key_cnt   = 3'h0;
                    end
                end
                ADDR_KEY_DATA:
                begin
                    // keys are silent: nothing is returned for them
                    if (key_armed)
                    begin
                        next_key_sh  = shifted;
                        next_key_cnt = key_cnt + 3'h1;
                        if (key_cnt == KEY_LAST_BYTE)
                        begin
                            next_key_armed = 1'b0;
                            // only exact signatures set anything
                            // setting one key never clears another
                            if (key_hit[0]) next_erase_key = 1'b1;
                            if (key_hit[1]) next_prog_key  = 1'b1;
                            if (key_hit[2]) next_row_key   = 1'b1;
                        end
                    end
                end
                ADDR_KEY_STATE:
                begin
                    if (hwdata[KS_ROW])
                    begin
                        next_row_key = 1'b0;
                    end
                end
                ADDR_RST_REQ: next_rst_req = hwdata[7:0];
                ADDR_SYS_CTRL:
                begin
                    next_clkreq = hwdata[SC_CLKREQ];
                    if (hwdata[SC_COMMIT] && row_flag && state == DKUS_IDLE)
                    begin
                        next_commit_bit = 1'b1;
                        next_row_commit = 1'b1;
                        next_state      = DKUS_COMMIT;
                    end
                end
                default:
                begin
                    // only the 32-word window takes data, and only in row mode
                    if (dp_addr[ROW_WIN_BIT] && row_flag)
                    begin
                        next_row_wr = 1'b1;
                    end
                end
            endcase
        end

        next_sys_reset = (next_rst_req == RESET_SIGNATURE);

        // key actions take effect as the host lets go of system reset
        if (sys_reset && !next_sys_reset)
        begin
            if (prog_flag)
            begin
                next_prog_flag = 1'b0;
                next_prog_key  = 1'b0;
            end
            else if (prog_key && !lock)
            begin
                next_prog_flag = 1'b1;
            end
            if (row_key && lock)
            begin
                next_row_flag = 1'b1;
            end
            if (erase_key && state == DKUS_IDLE)
            begin
                next_erase_start = 1'b1;
                next_state       = DKUS_ERASE;
            end
        end

        case (state)
            DKUS_IDLE: ;
            DKUS_ERASE:
            begin
                if (erase_done)
                begin
                    next_lock  = 1'b0;
                    next_state = DKUS_IDLE;
                end
            end
            DKUS_COMMIT:
            begin
                if (rif.done)
                begin
                    next_row_flag   = 1'b0;
                    next_commit_bit = 1'b0;
                    next_state      = DKUS_IDLE;
                end
            end
            default: next_state = DKUS_IDLE;
        endcase

        // disabling the interface is the other way out of the erase key
        if (link_disable)
        begin
            next_erase_key = 1'b0;
        end
        // emitted on the interface clock; no enable exists on purpose
        next_sync_event = sync_window && sync_line && !sync_prev;
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state           <= DKUS_IDLE;
            dp_wr           <= 1'b0;
            dp_addr         <= 8'h00;
            hrdata          <= 32'h00000000;
            key_armed       <= 1'b0;
            key_cnt         <= 3'h0;
            key_sh          <= 64'h0000000000000000;
            id_ptr          <= 4'h0;
            id_left         <= 5'h00;
            erase_key       <= 1'b0;
            prog_key        <= 1'b0;
            row_key         <= 1'b0;
            prog_flag       <= 1'b0;
            row_flag        <= 1'b0;
            commit_bit      <= 1'b0;
            clkreq          <= CLKREQ_RST;
            lock            <= 1'b1;
            lock_init       <= 1'b0;
            rst_req         <= RST_RELEASE;
            sys_reset       <= 1'b0;
            erase_start     <= 1'b0;
            sysbus_allow    <= 1'b0;
            sram_read_allow <= 1'b0;
            brownout_force  <= 1'b0;
            brownout_level  <= 3'h0;
            clock_request   <= CLKREQ_RST;
            sync_prev       <= 1'b0;
            sync_event      <= 1'b0;
            rif.wr          <= 1'b0;
            rif.idx         <= '0;
            rif.data        <= 8'h00;
            rif.commit      <= 1'b0;
        end
        else
        begin
            state           <= next_state;
            dp_wr           <= next_dp_wr;
            dp_addr         <= next_dp_addr;
            hrdata          <= next_hrdata;
            key_armed       <= next_key_armed;
            key_cnt         <= next_key_cnt;
            key_sh          <= next_key_sh;
            id_ptr          <= next_id_ptr;
            id_left         <= next_id_left;
            erase_key       <= next_erase_key;
            prog_key        <= next_prog_key;
            row_key         <= next_row_key;
            prog_flag       <= next_prog_flag;
            row_flag        <= next_row_flag;
            commit_bit      <= next_commit_bit;
            clkreq          <= next_clkreq;
            lock            <= next_lock;
            lock_init       <= next_lock_init;
            rst_req         <= next_rst_req;
            sys_reset       <= next_sys_reset;
            erase_start     <= next_erase_start;
            sysbus_allow    <= next_lock_init && !next_lock;
            sram_read_allow <= next_lock_init && !next_lock && !next_row_flag;
            brownout_force  <= (next_state == DKUS_ERASE);
            brownout_level  <= bod_fuse_level;
            clock_request   <= next_clkreq;
            sync_prev       <= sync_line;
            sync_event      <= next_sync_event;
            rif.wr          <= next_row_wr;
            rif.idx         <= next_row_idx;
            rif.data        <= next_row_data;
            rif.commit      <= next_row_commit;
        end
    end
endmodule
`default_nettype wire

// ===== test/dkus_top_props.sv
// port assertions for the debug key unlock sequencer
`timescale 1ns/1ps
`default_nettype none
module dkus_top_props (
    input wire logic       hclk,            // clock
    input wire logic       hresetn,         // reset, low
    input wire logic       sys_reset,       // system reset
    input wire logic       erase_start,     // erase pulse
    input wire logic       erase_done,      // erase end
    input wire logic       brownout_force,  // bod forced
    input wire logic [2:0] brownout_level,  // bod level
    input wire logic [2:0] bod_fuse_level,  // fuse level
    input wire logic       sysbus_allow,    // bus open
    input wire logic       sram_read_allow, // sram open
    input wire logic       sync_line,       // line level
    input wire logic       sync_window,     // sync active
    input wire logic       sync_event       // edge event
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sync_edge_a: assert property ($rose(sync_line) && sync_window |-> ##[1:2] sync_event)
        else $error("sync edge without event");
    sync_pulse_a: assert property (sync_event |=> !sync_event) else $error("event too long");
    erase_bod_a: assert property (erase_start |=> brownout_force) else $error("bod not forced");
    bod_level_a: assert property (brownout_force |-> brownout_level == bod_fuse_level)
        else $error("bod level differs from fuse");
    erase_end_a: assert property (brownout_force && erase_done |-> ##[1:3] !brownout_force)
        else $error("bod force stuck");
    erase_cause_a: assert property (erase_start |-> $past(sys_reset) || $past(sys_reset, 2))
        else $error("erase without reset release");
    erase_pulse_a: assert property (erase_start |=> !erase_start) else $error("erase pulse long");
    sram_lock_a: assert property (sram_read_allow |-> sysbus_allow) else $error("sram open locked");
endmodule
`default_nettype wire

// ===== test/dkus_nvm_model.sv
// stand-in for the memory controller that carries out a full erase
`timescale 1ns/1ps
`default_nettype none
module dkus_nvm_model (
    input  wire logic hclk,        // clock
    input  wire logic erase_start, // erase begins
    output logic      erase_done   // erase finished
);
    int cnt = 0;
    // erase takes some cycles so the host really has to poll
    always @(posedge hclk)
    begin
        cnt <= erase_start ? 12 : (cnt > 1) ? cnt - 1 : 0;
        erase_done <= (cnt == 2);
    end
endmodule
`default_nettype wire

// ===== test/dkus_top_tb.sv
// self-checking bench for the debug key unlock sequencer
`timescale 1ns/1ps
`default_nettype none
module dkus_top_tb;
    import dkus_pkg::*;
    localparam logic [127:0] ID = {8'h39, 8'h00, 24'h363534, 24'h333231, 8'h00, 56'h47464544434241};
    logic         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sync_line = 0, sync_window = 0;
    logic [1:0]   htrans = 0;
    logic [31:0]  haddr = 0, hwdata = 0, hrdata, q;
    logic         hreadyout, hresp, sys_reset, erase_start, erase_done, sysbus_allow;
    logic         sram_read_allow, brownout_force, clock_request, sync_event, link_disable = 0;
    logic [2:0]   brownout_level;
    logic [255:0] user_config_row, row;
    int           n_errors = 0, total_checks = 0, n_ev = 0;
    dkus_top #(.FAMILY_IDENTIFIER(ID[55:0]), .MEMCTL_VERSION(ID[87:64]),
        .DEBUG_VERSION(ID[111:88]), .DEBUG_OSC_FREQUENCY(ID[127:120])) i_dkus_top (.*,
        .hsize(3'h2), .hready(hreadyout), .lock_fuse(1'b1),
        .system_sleeping(1'b0), .bod_fuse_level(3'h5));
    dkus_nvm_model i_dkus_nvm_model (.hclk(hclk), .erase_start(erase_start), .erase_done(erase_done));
    initial forever #2.5 hclk = ~hclk;
    always @(posedge hclk) if (sync_event === 1'b1) n_ev++;
    task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // one ahb-lite single transfer; read data lands in q
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", 0, hresp);
    endtask
    task automatic key(input logic [63:0] k);
        xfer(32'h00, 1, 32'h0);
        for (int i = 0; i < 8; i++)
            xfer(32'h04, 1, {24'h0, k[8*i+:8]});
    endtask
    task automatic pulse_rst();
        xfer(32'h10, 1, 32'hA5);
        repeat (2) @(posedge hclk);
        chk("sys_reset", 1, sys_reset);
        xfer(32'h10, 1, 32'h0);
        repeat (2) @(posedge hclk);
        chk("sys_release", 0, sys_reset);
    endtask
    // bounded only by the watchdog
    task automatic poll(input int b, input logic v);
        do xfer(32'h18, 0, 32'h0); while (q[b] !== v);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #50us;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int s = 16; s > 0; s -= 8)
        begin
            xfer(32'h00, 1, (s == 16) ? 32'h3 : 32'h1);
            for (int i = 0; i <= s; i++)
            begin
                xfer(32'h08, 0, 32'h0);
                if (i != 7 && i != 14)
                    chk("id_byte", (i < s) ? ID[8*i+:8] : 8'h00, q);
            end
        end
        key(KEY_ERASE_SIG ^ 64'h1);
        xfer(32'h0C, 0, 32'h0);
        chk("bad_key", 0, q);
        key(KEY_PROG_SIG);
        key(KEY_ERASE_SIG);
        xfer(32'h0C, 0, 32'h0);
        chk("keys", 32'h18, q);
        chk("bus_locked", 0, sysbus_allow);
        pulse_rst();
        poll(SS_LOCK, 0);
        repeat (3) @(posedge hclk);
        chk("bus_open", 1, sysbus_allow);
        chk("sram_open", 1, sram_read_allow);
        pulse_rst();
        poll(SS_PROG, 1);
        pulse_rst();
        poll(SS_PROG, 0);
        xfer(32'h0C, 0, 32'h0);
        chk("prog_done", 32'h08, q);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(32'h0C, 0, 32'h0);
        chk("key_reset", 0, q);
        key(KEY_ERASE_SIG);
        link_disable <= 1'b1;
        @(posedge hclk);
        link_disable <= 1'b0;
        xfer(32'h0C, 0, 32'h0);
        chk("key_disabled", 0, q);
        key(KEY_ROW_SIG);
        pulse_rst();
        poll(SS_ROWPROG, 1);
        chk("sram_closed", 0, sram_read_allow);
        chk("clock_req", 1, clock_request);
        for (int i = 0; i < 33; i++)
        begin
            xfer(32'h80 + 4 * i, 1, 32'h40 + i);
            row[8*(i%32)+:8] = (i < 32) ? 8'h40 + i : row[7:0];
        end
        xfer(32'h14, 1, 32'h2);
        poll(SS_ROWPROG, 0);
        chk("user_row", row, user_config_row);
        chk("clock_req_off", 0, clock_request);
        xfer(32'h0C, 1, 32'h20);
        xfer(32'h0C, 0, 32'h0);
        chk("row_key_off", 0, q);
        pulse_rst();
        sync_window <= 1'b1;
        @(posedge hclk);
        repeat (4)
        begin
            sync_line <= 1'b1;
            repeat (2) @(posedge hclk);
            sync_line <= 1'b0;
            repeat (2) @(posedge hclk);
        end
        repeat (3) @(posedge hclk);
        chk("sync_events", 4, n_ev);
        print_verdict();
    end
endmodule
bind dkus_top dkus_top_props i_dkus_top_props (.*);
`default_nettype wire
